// *** hw/clamp_switch.sv ***
// Clamp switching decode: enable, invert select, loop speed and unlock override
`timescale 1ns/1ps
module clamp_switch
  import tv_trig_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Control inputs
  input  wire logic       display_clamp_enable,
  input  wire logic       channel_invert,
  input  wire logic       clamp_loop_speed,
  input  wire logic       pll_unlock_clamp_off,
  input  wire logic       back_porch,
  // Clamp controls
  output clamp_ctl_t      clamp_ctl
);

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  logic       clamp_on;
  clamp_ctl_t clamp_next;

  // Unlock overrides enable so no stale offset reaches the preamp
  assign clamp_on = display_clamp_enable & ~pll_unlock_clamp_off;

  always_comb
  begin
    clamp_next = '0;
    // Both shunts on while off; otherwise shunt only the unselected amp
    clamp_next.amp_normal_shunt = ~clamp_on | channel_invert;
    clamp_next.amp_invert_shunt = ~clamp_on | ~channel_invert;
    clamp_next.buffer_input_gnd = ~clamp_on;
    clamp_next.offset_line_conn = clamp_on;
    clamp_next.bias_enable      = clamp_on & back_porch;
    // Low speed bit adds capacitance; processor picks the settings
    clamp_next.extra_hold_cap   = ~clamp_loop_speed;
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Reset leaves the clamp safely off with both amps shunted
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clamp_ctl <= CLAMP_RESET_VALUE;
    end
    else
    begin
      clamp_ctl <= clamp_next;
    end
  end

endmodule : clamp_switch

// *** hw/tv_line_trigger_and_clamp_ctl.sv ***
// Video line trigger arming/firing logic and display clamp control top
`timescale 1ns/1ps

module tv_line_trigger_and_clamp_ctl
  import tv_trig_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Trigger control bits
  input  wire logic       video_trigger_enable,
  input  wire logic       line_coupling_select,
  input  wire logic       field_one_select,
  input  wire logic       field_two_select,
  // Timing inputs
  input  wire logic       a_holdoff_active,
  input  wire logic       line_sync_clock,
  input  wire logic       field_one_count_n,
  input  wire logic       field_two_count_n,
  // Clamp control bits
  input  wire logic       display_clamp_enable,
  input  wire logic       channel_invert,
  input  wire logic       clamp_loop_speed,
  input  wire logic       pll_unlock_clamp_off,
  input  wire logic       back_porch,
  // Outputs
  output logic            video_trigger_out_n,
  output logic            armed,
  output clamp_ctl_t      clamp_ctl
);

  // ----------------------------------------------------------------
  // Edge detection on synchronous inputs
  // ----------------------------------------------------------------
  logic line_sync_reg;
  logic count_pulse_reg;
  logic count_pulse;
  logic line_sync_rise;
  logic count_rise;

  // Counter outputs go low at terminal count; select gates one field
  assign count_pulse = (field_one_select & ~field_one_count_n)
                     | (field_two_select & ~field_two_count_n);

  assign line_sync_rise = line_sync_clock & ~line_sync_reg;
  assign count_rise     = count_pulse & ~count_pulse_reg;

  // Previous samples for edge detection
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      line_sync_reg   <= 1'b0;
      count_pulse_reg <= 1'b0;
    end
    else
    begin
      line_sync_reg   <= line_sync_clock;
      count_pulse_reg <= count_pulse;
    end
  end

  // ----------------------------------------------------------------
  // Arm / trigger state machine
  // ----------------------------------------------------------------
  trig_state_t state_reg;
  trig_state_t state_next;

  // Holdoff acts as a level clear, so it wins over every other term
  always_comb
  begin
    state_next = state_reg;
    if (a_holdoff_active || !video_trigger_enable)
    begin
      state_next = TRIG_IDLE;
    end
    else
    begin
      case (state_reg)
        TRIG_IDLE:
        begin
          // Line coupling forces set once holdoff is low
          if (line_coupling_select)
          begin
            state_next = TRIG_ARMED;
          end
          else if (count_rise)
          begin
            state_next = TRIG_ARMED;
          end
        end
        TRIG_ARMED:
        begin
          if (line_sync_rise)
          begin
            state_next = TRIG_FIRED;
          end
        end
        TRIG_FIRED:
        begin
          // Stays fired until the next holdoff or a low video_trigger_enable clears it
          state_next = TRIG_FIRED;
        end
        default:
        begin
          state_next = TRIG_IDLE;
        end
      endcase
    end
  end

  // State register; reset leaves nothing pending
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= TRIG_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Output low only while fired; held high otherwise
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      video_trigger_out_n <= ~TRIG_RESET_VALUE;
      armed               <= ARM_RESET_VALUE;
    end
    else
    begin
      video_trigger_out_n <= (state_next != TRIG_FIRED);
      armed               <= (state_next != TRIG_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Clamp switching
  // ----------------------------------------------------------------
  clamp_switch clamp_switch_inst (
    .sys_clk              (sys_clk),
    .resetn               (resetn),
    .display_clamp_enable (display_clamp_enable),
    .channel_invert       (channel_invert),
    .clamp_loop_speed     (clamp_loop_speed),
    .pll_unlock_clamp_off (pll_unlock_clamp_off),
    .back_porch           (back_porch),
    .clamp_ctl            (clamp_ctl)
  );

endmodule : tv_line_trigger_and_clamp_ctl

// *** hw/tv_trig_pkg.sv ***
// Package of types and constants for the video line trigger and clamp control
package tv_trig_pkg;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic ARM_RESET_VALUE  = 1'b0;
  localparam logic TRIG_RESET_VALUE = 1'b0;

  // ----------------------------------------------------------------
  // Trigger state encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIG_IDLE  = 2'b00,
    TRIG_ARMED = 2'b01,
    TRIG_FIRED = 2'b10
  } trig_state_t;

  // ----------------------------------------------------------------
  // Clamp control bundle toward the analog clamp
  // ----------------------------------------------------------------
  typedef struct packed {
    logic amp_normal_shunt;   // Shunt on offset amp for normal polarity
    logic amp_invert_shunt;   // Shunt on offset amp for inverted polarity
    logic buffer_input_gnd;   // Ground the offset buffer input
    logic offset_line_conn;   // Connect offset line to preamplifier
    logic bias_enable;        // Bias the selected amp (back porch only)
    logic extra_hold_cap;     // Add hold capacitance, slows loop
  } clamp_ctl_t;

  // Clamp off with both amps shunted and slow loop: 1,1,1,0,0,1
  localparam clamp_ctl_t CLAMP_RESET_VALUE = 6'h39;

endpackage : tv_trig_pkg

// *** verif/line_counter_model.sv ***
// Line counter and line sync source on the far side of the trigger
`timescale 1ns/1ps
module line_counter_model (
  // Clock and requests from the bench
  input  wire logic sys_clk,
  input  wire logic req_one, req_two, req_sync,
  // Counter outputs idle high, sync idles low
  output logic      line_sync_clock = 1'h0,
  output logic      field_one_count_n = 1'h1,
  output logic      field_two_count_n = 1'h1
);
  // One sys_clk-cycle pulse per request, no free-running sync so timing stays known
  always @(posedge sys_clk)
  begin
    field_one_count_n <= ~req_one;
    field_two_count_n <= ~req_two;
    line_sync_clock   <= req_sync;
  end
endmodule : line_counter_model

// *** verif/tv_line_trigger_and_clamp_ctl_bench.sv ***
// Self-checking bench for the video line trigger and clamp control
`timescale 1ns/1ps
module tv_line_trigger_and_clamp_ctl_bench
  import tv_trig_pkg::*;
;
  logic sys_clk = 0, resetn = 0, a_holdoff_active = 1, line_coupling_select = 0;
  logic video_trigger_enable = 1, field_one_select = 1, field_two_select = 0;
  logic display_clamp_enable = 1, channel_invert = 0, clamp_loop_speed = 1;
  logic pll_unlock_clamp_off = 0, back_porch = 0, req_one = 0, req_two = 0, req_sync = 0;
  logic line_sync_clock, field_one_count_n, field_two_count_n, video_trigger_out_n, armed;
  clamp_ctl_t clamp_ctl;
  logic [7:0] exp_q[$];
  int mismatches = 0, checked = 0, cycles = 0;
  event obs;

  always #5 sys_clk = ~sys_clk;
  tv_line_trigger_and_clamp_ctl tv_line_trigger_and_clamp_ctl_inst (.*);
  line_counter_model line_counter_model_inst (.*);

  // Clamp outputs worked out from the held control bits
  function automatic clamp_ctl_t ce();
    logic on;
    on = display_clamp_enable & ~pll_unlock_clamp_off;
    return '{on ? channel_invert : 1'h1, on ? ~channel_invert : 1'h1, ~on, on,
             on & back_porch, ~clamp_loop_speed};
  endfunction : ce

  task automatic step(int n);
    repeat (n) begin @(posedge sys_clk); #1; end
  endtask : step
  task automatic pulse(ref logic r);
    r = 1;
    step(1);
    r = 0;
  endtask : pulse
  // Note the expected trigger pair; the monitor compares it
  task automatic chk(logic [1:0] t);
    exp_q.push_back({t, ce()});
    -> obs;
  endtask : chk
  task automatic cmp(logic [7:0] seen, logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : cmp
  task finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Monitor: oldest note against the settled outputs
  always @(obs)
    cmp({video_trigger_out_n, armed, clamp_ctl}, exp_q.pop_front());
  // Hang guard, the run needs about 60 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 500)
    begin
      mismatches++;
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(32'hB868));
    step(4);
    resetn = 1;
    step(1); chk(2'h2);
    pulse(req_one); step(2); chk(2'h2);
    a_holdoff_active = 0;
    pulse(req_sync); step(2); chk(2'h2);
    pulse(req_two); step(2); chk(2'h2);
    pulse(req_one); step(2); chk(2'h3);
    pulse(req_sync); step(2); chk(2'h1);
    a_holdoff_active = 1;
    step(2); chk(2'h2);
    line_coupling_select = 1;
    a_holdoff_active = 0;
    step(2); chk(2'h3);
    pulse(req_sync); step(2); chk(2'h1);
    a_holdoff_active = 1;
    step(1);
    {line_coupling_select, a_holdoff_active, video_trigger_enable} = 3'h0;
    pulse(req_one); pulse(req_sync); step(2); chk(2'h2);
    {video_trigger_enable, field_one_select, field_two_select} = 3'h5;
    pulse(req_two); step(2); chk(2'h3);
    a_holdoff_active = 1;
    // Random clamp bits, loop speed included as the processor would set it
    repeat (24)
    begin
      {display_clamp_enable, channel_invert, clamp_loop_speed, pll_unlock_clamp_off,
       back_porch} = 5'($urandom);
      step(1); chk(2'h2);
    end
    step(1);
    finish_test();
  end
endmodule : tv_line_trigger_and_clamp_ctl_bench

bind tv_line_trigger_and_clamp_ctl tv_trig_properties tv_trig_properties_inst (.*);

// *** verif/tv_trig_properties.sv ***
// Concurrent checks on the trigger and clamp control ports
`timescale 1ns/1ps
module tv_trig_properties
  import tv_trig_pkg::*;
(
  // All ports of the top module, watched only
  input wire logic sys_clk, resetn, video_trigger_enable, line_coupling_select,
  input wire logic field_one_select, field_two_select, a_holdoff_active, line_sync_clock,
  input wire logic field_one_count_n, field_two_count_n, display_clamp_enable,
  input wire logic channel_invert, clamp_loop_speed, pll_unlock_clamp_off, back_porch,
  input wire logic video_trigger_out_n, armed,
  input wire clamp_ctl_t clamp_ctl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Trigger state, one cycle after its cause
  hold_clears_a:
    assert property (a_holdoff_active |=> video_trigger_out_n && !armed)
      else $error("holdoff left trigger state set");
  enable_clears_a:
    assert property (!video_trigger_enable |=> video_trigger_out_n && !armed)
      else $error("disabled trigger not idle");
  coupling_arm_a:
    assert property (!a_holdoff_active && video_trigger_enable && line_coupling_select |=> armed)
      else $error("line coupling did not arm");
  field_arm_a:
    assert property (!a_holdoff_active && video_trigger_enable
      && (field_one_select && $fell(field_one_count_n)
      || field_two_select && $fell(field_two_count_n)) |=> armed)
      else $error("selected field pulse did not arm");
  no_stray_arm_a:
    assert property (!armed && !line_coupling_select
      && !(field_one_select && $fell(field_one_count_n))
      && !(field_two_select && $fell(field_two_count_n)) |=> !armed)
      else $error("armed without a selected pulse");
  fire_next_a:
    assert property (armed && !a_holdoff_active && video_trigger_enable
      && $rose(line_sync_clock) |=> !video_trigger_out_n)
      else $error("armed trigger missed line sync");
  fire_needs_arm_a:
    assert property (!armed |=> video_trigger_out_n)
      else $error("trigger fired while unarmed");
  // Clamp decode, one cycle after its inputs
  clamp_off_a:
    assert property (!display_clamp_enable || pll_unlock_clamp_off |=> clamp_ctl[5:1] == 5'h1C)
      else $error("clamp not fully off");
  clamp_on_a:
    assert property (display_clamp_enable && !pll_unlock_clamp_off |=> clamp_ctl[3:2] == 2'h1
      && clamp_ctl[5:4] == {$past(channel_invert), !$past(channel_invert)})
      else $error("clamp on decode wrong");
  bias_window_a:
    assert property (1'h1 |=> clamp_ctl.bias_enable
      == $past(display_clamp_enable && !pll_unlock_clamp_off && back_porch))
      else $error("bias outside back porch");
  hold_cap_a:
    assert property (1'h1 |=> clamp_ctl.extra_hold_cap != $past(clamp_loop_speed))
      else $error("hold capacitance wrong");

  // Main scenarios reached
  cover property (!video_trigger_out_n && !line_coupling_select);
  cover property (!video_trigger_out_n && line_coupling_select);
  cover property (clamp_ctl.bias_enable);
endmodule : tv_trig_properties
